// ===== hw/rsfs_top.sv
/*
  Per-rail sequencing, soft-start, power good, fault response and current readback.
  Assumes comparator and converter codes arrive synchronous to MCLK_I from the power stage.
*/
`timescale 1ns/10ps
module rsfs_top
  import rsfs_pkg::*;
#(
  parameter int FREE_HALF_CYCLES = 100
) (
  input  wire logic                            MCLK_I,
  input  wire logic                            SYS_RST_I,
  input  wire logic                            SYNC_EN_I,
  input  wire logic                            SYNC_I,
  input  wire logic                            TWO_PHASE_I,
  input  wire logic [VIN_W-1:0]                VIN_CODE_I,
  input  wire logic [VIN_W-1:0]                VIN_ON_I,
  input  wire logic [VIN_W-1:0]                VIN_OFF_I,
  input  wire logic [NUM_RAILS-1:0]            RAIL_CONTROL_PIN_I,
  input  wire logic [NUM_RAILS-1:0]            CTRL_POL_HIGH_I,
  input  wire logic [NUM_RAILS-1:0]            OPERATION_ON_I,
  input  wire logic [2*NUM_RAILS-1:0]          ONOFF_CFG_I,
  input  wire logic [TIME_W*NUM_RAILS-1:0]     TON_DELAY_US_I,
  input  wire logic [TIME_W*NUM_RAILS-1:0]     TOFF_DELAY_US_I,
  input  wire logic [RISE_SEL_W*NUM_RAILS-1:0] TON_RISE_SEL_I,
  input  wire logic [PG_SEL_W*NUM_RAILS-1:0]   PG_ON_SEL_I,
  input  wire logic [PG_SEL_W*NUM_RAILS-1:0]   PG_OFF_SEL_I,
  input  wire logic [FB_W*NUM_RAILS-1:0]       FEEDBACK_INPUT_I,
  input  wire logic [NUM_RAILS-1:0]            OC_SENSE_I,
  input  wire logic [NUM_RAILS-1:0]            OC_LATCH_I,
  input  wire logic [SR_W*NUM_RAILS-1:0]       DUTY_COMP_I,
  input  wire logic [IOUT_W*NUM_RAILS-1:0]     IOUT_CODE_I,
  output logic      [NUM_RAILS-1:0]            SW_CLK_O,
  output logic      [NUM_RAILS-1:0]            HIGH_SIDE_GATE_DRIVE_EN_O,
  output logic      [NUM_RAILS-1:0]            LOW_SIDE_GATE_DRIVE_EN_O,
  output logic      [NUM_RAILS-1:0]            LOW_SIDE_GATE_DRIVE_HOLD_O,
  output logic      [SR_W*NUM_RAILS-1:0]       LOW_SIDE_ONTIME_O,
  output logic      [FB_W*NUM_RAILS-1:0]       SOFT_START_O,
  output logic      [NUM_RAILS-1:0]            POWER_GOOD_OUTPUT_O,
  output logic      [NUM_RAILS-1:0]            PG_FLAG_CLEAR_O,
  output logic      [NUM_RAILS-1:0]            OC_FAULT_O,
  output logic      [NUM_RAILS-1:0]            OV_FAULT_O,
  output logic      [NUM_RAILS-1:0]            UV_FAULT_O,
  output logic      [IOUT_W*NUM_RAILS-1:0]     IOUT_READ_O,
  output logic      [8*NUM_RAILS-1:0]          RAIL_STATE_O
);

  // --------------------------------------------------------------------------
  // switching clock
  // --------------------------------------------------------------------------
  rsfs_sw_if sw ();

  rsfs_swclk #(
    .FREE_HALF_CYCLES (FREE_HALF_CYCLES)
  ) u_swclk (
    .clk_i     (MCLK_I),
    .rst_i     (SYS_RST_I),
    .sync_en_i (SYNC_EN_I),
    .sync_i    (SYNC_I),
    .sw        (sw.src)
  );

  assign SW_CLK_O = sw.sw_clk;

  // --------------------------------------------------------------------------
  // microsecond tick and input lockout
  // --------------------------------------------------------------------------
  logic [US_CNT_W-1:0] us_cnt;
  logic [US_CNT_W-1:0] next_us_cnt;
  logic                us_tick;
  logic                vin_ok;
  logic                next_vin_ok;
  logic [VIN_W-1:0]    vin_on_thr;
  logic [VIN_W-1:0]    vin_off_thr;

  always_comb begin
    us_tick     = (us_cnt == US_CNT_LAST);
    next_us_cnt = us_tick ? '0 : us_cnt + US_CNT_W'(1);
    vin_off_thr = (VIN_OFF_I < UVLO_OFF_MIN) ? UVLO_OFF_MIN : VIN_OFF_I;   // [R11]
    vin_on_thr  = (VIN_ON_I > UVLO_ON_MAX) ? UVLO_ON_MAX : VIN_ON_I;       // [R11]
    next_vin_ok = vin_ok ? (VIN_CODE_I > vin_off_thr)                      // [R11]
                         : (VIN_CODE_I >= vin_on_thr);
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      us_cnt <= '0;
      vin_ok <= 1'b0;
    end else begin
      us_cnt <= next_us_cnt;
      vin_ok <= next_vin_ok;
    end
  end

  // --------------------------------------------------------------------------
  // per-rail supervisor
  // --------------------------------------------------------------------------
  for (genvar r = 0; r < NUM_RAILS; r++) begin : g_rail
    localparam int RS = (r == 0) ? 0 : 1;
    rsfs_state_e       state;
    rsfs_state_e       next_state;
    logic [TIME_W-1:0] tmr;
    logic [TIME_W-1:0] next_tmr;
    logic [TIME_W-1:0] acc;
    logic [TIME_W-1:0] next_acc;
    logic [FB_W-1:0]   ss;
    logic [FB_W-1:0]   next_ss;
    logic              started;
    logic              next_started;
    logic [SR_W-1:0]   sr_w;
    logic [SR_W-1:0]   next_sr_w;
    logic [1:0]        occnt;
    logic [1:0]        next_occnt;
    logic [2:0]        hic;
    logic [2:0]        next_hic;
    logic              pg;
    logic              next_pg;
    logic              flag_clr;
    logic              next_flag_clr;
    logic [IOUT_W-1:0] iout;
    logic [IOUT_W-1:0] next_iout;
    logic              ocf;
    logic              ovf;
    logic              uvf;
    logic              next_ocf;
    logic              next_ovf;
    logic              next_uvf;
    // inputs as this rail sees them; two-phase mode: phase two copies phase one, both see ORed overcurrent sense, own duty comparator and current code
    logic              src;
    logic [1:0]        cfg;
    logic              pin_act;
    logic              gate;
    logic [FB_W-1:0]   fb;
    logic              oc_in;
    logic              tick;
    logic [TIME_W-1:0] rt;
    logic [FB_W-1:0]   on_band;
    logic [FB_W-1:0]   off_band;
    logic              ov;
    logic              uv;
    logic              in_on;
    logic              in_off;
    logic              oc_trip;
    logic              switching;
    logic [TIME_W:0]   acc_sum;
    logic [SR_W:0]     sr_sum;
    logic [SR_W-1:0]   comp;

    always_comb begin
      src      = (TWO_PHASE_I && r == 1) ? 1'b0 : RS[0];           // [R15] [R14]
      cfg      = ONOFF_CFG_I[2*src +: 2];
      pin_act  = ~(RAIL_CONTROL_PIN_I[src] ^ CTRL_POL_HIGH_I[src]);  // [R22]
      case (cfg)                                                   // [R21]
        ONOFF_PIN_ONLY:    gate = vin_ok & pin_act;                // [R5]
        ONOFF_CMD_ONLY:    gate = vin_ok & OPERATION_ON_I[src];
        ONOFF_PIN_AND_CMD: gate = vin_ok & pin_act & OPERATION_ON_I[src];
        default:           gate = vin_ok;
      endcase
      fb       = FEEDBACK_INPUT_I[FB_W*src +: FB_W];               // [R15]
      oc_in    = TWO_PHASE_I ? |OC_SENSE_I : OC_SENSE_I[r];        // [R15]
      tick     = TWO_PHASE_I ? sw.sw_tick[0] : sw.sw_tick[r];
      rt       = RISE_US[TON_RISE_SEL_I[RISE_SEL_W*src +: RISE_SEL_W]];  // [R4]
      on_band  = PG_BAND[(PG_ON_SEL_I[PG_SEL_W*src +: PG_SEL_W] > 2'h2) ? 2'h2
                         : PG_ON_SEL_I[PG_SEL_W*src +: PG_SEL_W]];  // [R16]
      off_band = PG_BAND[(PG_OFF_SEL_I[PG_SEL_W*src +: PG_SEL_W] > 2'h2) ? 2'h2
                         : PG_OFF_SEL_I[PG_SEL_W*src +: PG_SEL_W]];
      comp     = DUTY_COMP_I[SR_W*r +: SR_W];
      ov       = fb > (FB_NOMINAL + FB_OV_DELTA);
      uv       = fb < (FB_NOMINAL - FB_UV_DELTA);
      in_on    = (fb >= FB_NOMINAL - on_band) && (fb <= FB_NOMINAL + on_band);     // [R16]
      in_off   = (fb >= FB_NOMINAL - off_band) && (fb <= FB_NOMINAL + off_band);   // [R17]
      switching = (state == ST_RAMP) || (state == ST_REG);
      oc_trip  = switching & tick & oc_in & (occnt == OC_TRIP_CYCLES - 2'h1);      // [R19]
      acc_sum  = {1'b0, acc} + (TIME_W+1)'(FB_NOMINAL);
      sr_sum   = {1'b0, sr_w} + {1'b0, SR_STEP};

      next_state   = state;
      next_tmr     = tmr;
      next_acc     = acc;
      next_ss      = ss;
      next_started = started;
      next_sr_w    = sr_w;
      next_hic     = hic;
      next_ocf     = 1'b0;
      next_ovf     = 1'b0;
      next_uvf     = 1'b0;
      next_occnt   = (switching && tick) ? (oc_in ? occnt + 2'h1 : 2'h0)
                   : (switching ? occnt : 2'h0);

      case (state)                                                 // [R23]
        ST_OFF: begin
          next_ss   = '0;
          next_sr_w = '0;
          if (gate) begin                                          // [R5]
            next_state = ST_TON;
            next_tmr   = '0;
          end
        end
        ST_TON: begin
          if (!gate) begin
            next_state = ST_OFF;
          end else if (tmr >= TON_DELAY_US_I[TIME_W*src +: TIME_W]) begin  // [R6]
            next_state   = ST_RAMP;
            next_acc     = '0;
            next_ss      = '0;
            next_started = 1'b0;
            next_sr_w    = '0;
          end else if (us_tick) begin
            next_tmr = tmr + 16'h0001;
          end
        end
        ST_RAMP, ST_REG: begin
          if (!gate) begin                                         // [R7]
            next_state = ST_TOFF;
            next_tmr   = '0;
          end else if (oc_trip) begin                              // [R19]
            next_ocf   = 1'b1;
            next_state = OC_LATCH_I[src] ? ST_LATCH : ST_HICCUP;
            next_tmr   = '0;
            next_hic   = '0;
          end else if (ov) begin                                   // [R13]
            next_ovf   = 1'b1;
            next_state = ST_OVDIS;
          end else if (state == ST_REG && uv) begin                // [R12]
            next_uvf   = 1'b1;
            next_state = ST_HICCUP;
            next_tmr   = '0;
            next_hic   = '0;
          end else if (state == ST_REG) begin
            next_sr_w = comp;
          end else begin
            if (us_tick) begin                                     // [R6]
              if (acc_sum >= {1'b0, rt}) begin
                next_acc = TIME_W'(acc_sum - {1'b0, rt});
                next_ss  = ss + 10'h001;
              end else begin
                next_acc = acc_sum[TIME_W-1:0];
              end
            end
            if (ss > fb) begin                                     // [R9]
              next_started = 1'b1;
            end
            if (started && tick) begin                             // [R10]
              if (sr_w == '0) begin
                next_sr_w = SR_START_WIDTH;
              end else if (sr_sum >= {1'b0, comp}) begin
                next_sr_w = comp;
              end else begin
                next_sr_w = sr_sum[SR_W-1:0];
              end
            end
            if (ss >= FB_NOMINAL) begin
              next_state = ST_REG;
            end
          end
        end
        ST_TOFF: begin
          if (gate) begin
            next_state = ST_REG;
          end else if (tmr >= TOFF_DELAY_US_I[TIME_W*src +: TIME_W]) begin  // [R7]
            next_state = ST_OFF;
          end else if (us_tick) begin
            next_tmr = tmr + 16'h0001;
          end
        end
        ST_OVDIS: begin
          if (!gate) begin
            next_state = ST_OFF;
          end else if (in_on) begin                                // [R13]
            next_state = ST_REG;
          end
        end
        ST_HICCUP: begin
          if (!gate) begin
            next_state = ST_OFF;
          end else if (us_tick) begin                              // [R20]
            if (tmr + 16'h0001 >= rt) begin
              next_tmr = '0;
              if (hic == HICCUP_SS_PERIODS - 3'h1) begin           // [R12] [R20]
                next_state   = ST_RAMP;
                next_acc     = '0;
                next_ss      = '0;
                next_started = 1'b0;
                next_sr_w    = '0;
              end else begin
                next_hic = hic + 3'h1;
              end
            end else begin
              next_tmr = tmr + 16'h0001;
            end
          end
        end
        ST_LATCH: begin
          if (!gate) begin                                         // [R19]
            next_state = ST_OFF;
          end
        end
        default: begin
          next_state = ST_OFF;
        end
      endcase

      next_pg   = (state == ST_REG) && (next_state == ST_REG)      // [R8] [R18]
                  && (pg ? in_off : in_on);                        // [R16]
      next_flag_clr = next_pg & ~pg;                               // [R16]
      next_iout = IOUT_CODE_I[IOUT_W*r + IOUT_W-1] ? '0            // [R3]
                : IOUT_CODE_I[IOUT_W*r +: IOUT_W];
    end

    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        state    <= ST_OFF;
        tmr      <= '0;
        acc      <= '0;
        ss       <= '0;
        started  <= 1'b0;
        sr_w     <= '0;
        occnt    <= 2'h0;
        hic      <= 3'h0;
        pg       <= 1'b0;
        flag_clr <= 1'b0;
        iout     <= '0;
        ocf      <= 1'b0;
        ovf      <= 1'b0;
        uvf      <= 1'b0;
      end else begin
        state    <= next_state;
        tmr      <= next_tmr;
        acc      <= next_acc;
        ss       <= next_ss;
        started  <= next_started;
        sr_w     <= next_sr_w;
        occnt    <= next_occnt;
        hic      <= next_hic;
        pg       <= next_pg;
        flag_clr <= next_flag_clr;
        iout     <= next_iout;
        ocf      <= next_ocf;
        ovf      <= next_ovf;
        uvf      <= next_uvf;
      end
    end

    // gate enables decode the registered state
    assign HIGH_SIDE_GATE_DRIVE_EN_O[r]  = (state == ST_REG) || (state == ST_TOFF)
                                         || ((state == ST_RAMP) && started);     // [R9]
    assign LOW_SIDE_GATE_DRIVE_EN_O[r]   = HIGH_SIDE_GATE_DRIVE_EN_O[r]
                                         || (state == ST_OVDIS);
    assign LOW_SIDE_GATE_DRIVE_HOLD_O[r] = (state == ST_OVDIS);                  // [R13]
    assign LOW_SIDE_ONTIME_O[SR_W*r +: SR_W] = sr_w;
    assign SOFT_START_O[FB_W*r +: FB_W]      = ss;
    assign POWER_GOOD_OUTPUT_O[r]        = pg;
    assign PG_FLAG_CLEAR_O[r]            = flag_clr;
    assign OC_FAULT_O[r]                 = ocf;
    assign OV_FAULT_O[r]                 = ovf;
    assign UV_FAULT_O[r]                 = uvf;
    assign IOUT_READ_O[IOUT_W*r +: IOUT_W] = iout;
    assign RAIL_STATE_O[8*r +: 8]        = state;
  end

endmodule : rsfs_top

// ===== hw/rsfs_pkg.sv
/*
  Constants, timing counts and state codes for the rail sequencing and fault supervisor.
  Assumes a single 100 MHz clock and analog measurements already turned into codes.
*/
// Contract
// R1: host's external sync clock runs at twice switching rate, within plus or minus 20%.
// R2: each phase switches at half the external sync clock frequency.
// R3: current readback reports sourcing current only; sinking reads as zero.
// R4: soft-start ramp time selectable from a table spanning 600 us to 9 ms.
// R5: rail starts only when lockout clear and its selected pin/command gating is met.
// R6: after gating goes true, wait turn-on delay, then ramp over programmed rise time.
// R7: after gating goes false, wait turn-off delay, then inhibit switching.
// R8: power good asserts after start-up once feedback reaches the power-good threshold.
// R9: with pre-biased output, no pulses until soft-start exceeds feedback.
// R10: rectifier on-time starts narrow and grows each cycle up to (1-D).
// R11: lockout on/off thresholds independent; off at least 4 V, on at most 16 V.
// R12: undervoltage fault enters hiccup restart, normal regulation after fault clears.
// R13: overvoltage turns high side off, holds low side on until back in window.
// R14: dual-output mode gives each channel its own independent fault protection.
// R15: two-phase mode watches only first channel feedback; both phases act together.
// R16: power-good band from three symmetric options; crossing clears related host flags.
// R17: host sets power-good release band wider than the power-good assert band.
// R18: power good low during start-up, after faults, and whenever rail off or disabled.
// R19: three consecutive overcurrent cycles turn both switches off, then hiccup or latch.
// R20: hiccup waits seven soft-start periods before retrying, repeating while fault stays.
// R21: on/off config picks pin-only, command-only or both; unselected source ignored.
// R22: rail control pin polarity selectable active high or active low.
// R23: each rail runs its own off/delay/ramp/regulate/delay machine; faults override.
package rsfs_pkg;

  localparam int NUM_RAILS        = 2;

  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int US_TICK_NS       = 1000;
  localparam int US_TICK_CYCLES   = (US_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_CNT_W         = 7;
  localparam logic [US_CNT_W-1:0] US_CNT_LAST = US_CNT_W'(US_TICK_CYCLES - 1);

  // --------------------------------------------------------------------------
  // soft-start table, microseconds
  // --------------------------------------------------------------------------
  localparam int RISE_SEL_W       = 3;
  localparam int TIME_W           = 16;
  localparam logic [TIME_W-1:0] RISE_US [8] = '{16'h0258, 16'h0384, 16'h04B0, 16'h0708,
                                                16'h0A8C, 16'h0E10, 16'h1770, 16'h2328};

  // --------------------------------------------------------------------------
  // feedback codes, 1 mV per step
  // --------------------------------------------------------------------------
  localparam int FB_W             = 10;
  localparam logic [FB_W-1:0] FB_NOMINAL  = 10'h258;
  localparam logic [FB_W-1:0] FB_OV_DELTA = 10'h05A;
  localparam logic [FB_W-1:0] FB_UV_DELTA = 10'h05A;
  localparam int PG_SEL_W         = 2;
  localparam logic [FB_W-1:0] PG_BAND [3] = '{10'h01E, 10'h02D, 10'h03C};

  // --------------------------------------------------------------------------
  // input lockout, 100 mV per step
  // --------------------------------------------------------------------------
  localparam int VIN_W            = 8;
  localparam logic [VIN_W-1:0] UVLO_OFF_MIN = 8'h28;
  localparam logic [VIN_W-1:0] UVLO_ON_MAX  = 8'hA0;

  // --------------------------------------------------------------------------
  // faults and rectifier
  // --------------------------------------------------------------------------
  localparam logic [1:0] OC_TRIP_CYCLES    = 2'h3;
  localparam logic [2:0] HICCUP_SS_PERIODS = 3'h7;
  localparam int SR_W             = 8;
  localparam logic [SR_W-1:0] SR_START_WIDTH = 8'h01;
  localparam logic [SR_W-1:0] SR_STEP        = 8'h01;
  localparam int IOUT_W           = 12;

  // --------------------------------------------------------------------------
  // on/off configuration
  // --------------------------------------------------------------------------
  localparam logic [1:0] ONOFF_LOCKOUT_ONLY = 2'h0;
  localparam logic [1:0] ONOFF_PIN_ONLY     = 2'h1;
  localparam logic [1:0] ONOFF_CMD_ONLY     = 2'h2;
  localparam logic [1:0] ONOFF_PIN_AND_CMD  = 2'h3;

  typedef enum logic [7:0] {
    ST_OFF    = 8'h01,
    ST_TON    = 8'h02,
    ST_RAMP   = 8'h04,
    ST_REG    = 8'h08,
    ST_TOFF   = 8'h10,
    ST_OVDIS  = 8'h20,
    ST_HICCUP = 8'h40,
    ST_LATCH  = 8'h80
  } rsfs_state_e;

endpackage : rsfs_pkg

// ===== hw/rsfs_sw_if.sv
/*
  Switching-cycle ticks and phase clocks passed from the clock divider to the rails.
  Assumes both ends run on the one system clock.
*/
`timescale 1ns/10ps
interface rsfs_sw_if;
  logic [1:0] sw_tick;
  logic [1:0] sw_clk;
  modport src (output sw_tick, output sw_clk);
  modport snk (input sw_tick, input sw_clk);
endinterface : rsfs_sw_if

// ===== hw/rsfs_swclk.sv
/*
  Two-phase switching clock: half the external sync clock, or a free-running divider.
  Assumes the sync input is already synchronous to the system clock.
*/
`timescale 1ns/10ps
module rsfs_swclk
  import rsfs_pkg::*;
#(
  parameter int FREE_HALF_CYCLES = 100
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sync_en_i,
  input  wire logic sync_i,
  rsfs_sw_if.src    sw
);

  logic        sync_q;
  logic        tog;
  logic [15:0] cnt;
  logic [1:0]  tick;
  logic        next_sync_q;
  logic        next_tog;
  logic [15:0] next_cnt;
  logic [1:0]  next_tick;
  logic        edge_hit;

  // --------------------------------------------------------------------------
  // divide by two, alternate phases
  // --------------------------------------------------------------------------
  always_comb begin
    next_sync_q = sync_i;
    next_cnt    = cnt;
    edge_hit    = 1'b0;
    if (sync_en_i) begin
      edge_hit = sync_i & ~sync_q;
      next_cnt = '0;
    end else if (cnt >= 16'(FREE_HALF_CYCLES - 1)) begin
      edge_hit = 1'b1;
      next_cnt = '0;
    end else begin
      next_cnt = cnt + 16'h0001;
    end
    next_tog  = edge_hit ? ~tog : tog;                            // [R2]
    next_tick = edge_hit ? {tog, ~tog} : 2'h0;                    // [R2]
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_q <= 1'b0;
      tog    <= 1'b0;
      cnt    <= '0;
      tick   <= 2'h0;
    end else begin
      sync_q <= next_sync_q;
      tog    <= next_tog;
      cnt    <= next_cnt;
      tick   <= next_tick;
    end
  end

  assign sw.sw_tick = tick;
  assign sw.sw_clk  = {tog, ~tog};

endmodule : rsfs_swclk

// ===== bench/rsfs_top_asserts.sv
/* rail 0 checker for rsfs_top; assumes binding to the top ports */
`timescale 1ns/10ps
module rsfs_top_asserts (
  input wire logic        MCLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        SYNC_EN_I,
  input wire logic        SYNC_I,
  input wire logic [23:0] IOUT_CODE_I,
  input wire logic [19:0] FEEDBACK_INPUT_I,
  input wire logic [1:0]  SW_CLK_O,
  input wire logic [1:0]  HIGH_SIDE_GATE_DRIVE_EN_O,
  input wire logic [1:0]  LOW_SIDE_GATE_DRIVE_EN_O,
  input wire logic [1:0]  LOW_SIDE_GATE_DRIVE_HOLD_O,
  input wire logic [19:0] SOFT_START_O,
  input wire logic [1:0]  POWER_GOOD_OUTPUT_O,
  input wire logic [1:0]  PG_FLAG_CLEAR_O,
  input wire logic [1:0]  OC_FAULT_O,
  input wire logic [1:0]  OV_FAULT_O,
  input wire logic [1:0]  UV_FAULT_O,
  input wire logic [23:0] IOUT_READ_O,
  input wire logic [15:0] RAIL_STATE_O
);
  wire [7:0] st = RAIL_STATE_O[7:0];
  wire       hs = HIGH_SIDE_GATE_DRIVE_EN_O[0];
  wire       pg = POWER_GOOD_OUTPUT_O[0];
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_fault; OC_FAULT_O[0] || OV_FAULT_O[0] || UV_FAULT_O[0]; endsequence
  sequence s_pg_rise; $rose(pg); endsequence
  a_swclk_phases: assert property (SW_CLK_O[1] == !SW_CLK_O[0])
    else $error("phase clocks not opposite");
  a_sync_divide: assert property (SYNC_EN_I && $rose(SYNC_I) |=>
    SW_CLK_O != $past(SW_CLK_O))
    else $error("phase clock missed sync edge");
  a_iout_sink_zero: assert property (IOUT_CODE_I[11] |=> IOUT_READ_O[11:0] == 12'h000)
    else $error("sinking current not read as zero");
  a_iout_source: assert property (!IOUT_CODE_I[11] |=>
    IOUT_READ_O[11:0] == $past(IOUT_CODE_I[11:0]))
    else $error("sourcing current misread");
  a_off_quiet: assert property (st == 8'h01 |-> !hs && !LOW_SIDE_GATE_DRIVE_EN_O[0])
    else $error("switching while off");
  a_ov_hold: assert property (st == 8'h20 |-> LOW_SIDE_GATE_DRIVE_HOLD_O[0] && !hs)
    else $error("overvoltage discharge wrong");
  a_ov_entry: assert property ($rose(st == 8'h20) |-> OV_FAULT_O[0])
    else $error("overvoltage entry without pulse");
  a_prebias_wait: assert property ($rose(hs) && st == 8'h04 |->
    $past(SOFT_START_O[9:0] > FEEDBACK_INPUT_I[9:0]))
    else $error("pulses before soft-start passed feedback");
  a_pg_in_reg: assert property (pg |-> st == 8'h08 || $past(st) == 8'h08)
    else $error("power good outside regulation");
  a_fault_pg_low: assert property (s_fault |-> !pg)
    else $error("power good during fault");
  a_flag_clear: assert property (s_pg_rise |-> PG_FLAG_CLEAR_O[0])
    else $error("flag clear pulse missing");
endmodule : rsfs_top_asserts
bind rsfs_top rsfs_top_asserts u_chk (.*);

// ===== bench/rsfs_stage_model.sv
/* power stage model for rail 0 feedback; assumes dut outputs on clk_i */
`timescale 1ns/10ps
module rsfs_stage_model (
  input  wire logic       clk_i,
  input  wire logic       hs_en_i,
  input  wire logic       ls_hold_i,
  input  wire logic       over_i,
  input  wire logic [9:0] ss_i,
  output logic      [9:0] fb_o
);
  initial fb_o = 10'h0C8; // pre-biased output
  always @(posedge clk_i) begin
    if (over_i) fb_o <= 10'h2D0;
    else if (ls_hold_i || (hs_en_i && ss_i > fb_o)) fb_o <= ss_i;
  end
endmodule : rsfs_stage_model

// ===== bench/rsfs_top_tb.sv
/* self-checking bench for rsfs_top; assumes the stage model on rail 0 */
`timescale 1ns/10ps
module rsfs_top_tb;
  import rsfs_pkg::*;
  logic MCLK_I = 0, SYS_RST_I = 1, SYNC_EN_I = 0, SYNC_I = 0, TWO_PHASE_I = 0, over = 0;
  logic [7:0]  VIN_CODE_I = 8'h78, VIN_ON_I = 8'h50, VIN_OFF_I = 8'h40;
  logic [1:0]  RAIL_CONTROL_PIN_I = 2'h1, CTRL_POL_HIGH_I = 2'h0, OPERATION_ON_I = 2'h1;
  logic [1:0]  OC_SENSE_I = 2'h0, OC_LATCH_I = 2'h0;
  logic [3:0]  ONOFF_CFG_I = 4'h9, PG_ON_SEL_I = 4'h0, PG_OFF_SEL_I = 4'hA;
  logic [31:0] TON_DELAY_US_I = 32'h00000002, TOFF_DELAY_US_I = 32'h00000003;
  logic [5:0]  TON_RISE_SEL_I = 6'h00;
  logic [15:0] DUTY_COMP_I = 16'h0020;
  logic [23:0] IOUT_CODE_I = 24'h000000;
  logic [1:0]  SW_CLK_O, HIGH_SIDE_GATE_DRIVE_EN_O, LOW_SIDE_GATE_DRIVE_EN_O;
  logic [1:0]  LOW_SIDE_GATE_DRIVE_HOLD_O, POWER_GOOD_OUTPUT_O, PG_FLAG_CLEAR_O;
  logic [1:0]  OC_FAULT_O, OV_FAULT_O, UV_FAULT_O;
  logic [15:0] LOW_SIDE_ONTIME_O, RAIL_STATE_O;
  logic [19:0] SOFT_START_O;
  logic [23:0] IOUT_READ_O;
  wire  [9:0]  fb;
  wire  [19:0] FEEDBACK_INPUT_I = {10'h000, fb};
  int error_cnt = 0, n_tests = 0, cyc = 0, w;
  always #5 MCLK_I = ~MCLK_I;
  rsfs_top #(.FREE_HALF_CYCLES(4)) dut (.*);
  rsfs_stage_model u_stage (.clk_i(MCLK_I), .hs_en_i(HIGH_SIDE_GATE_DRIVE_EN_O[0]),
    .ls_hold_i(LOW_SIDE_GATE_DRIVE_HOLD_O[0]), .over_i(over), .ss_i(SOFT_START_O[9:0]), .fb_o(fb));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge MCLK_I);
    #1;
  endtask : tick
  task wait_st(input logic [7:0] s, input int lim);
    w = 0;
    while (RAIL_STATE_O[7:0] !== s && w < lim) begin
      tick(1);
      w++;
    end
    chk(RAIL_STATE_O[7:0], s);
  endtask : wait_st
  task results;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  always @(posedge MCLK_I) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    tick(20);
    SYS_RST_I = 0;
    chk(RAIL_STATE_O, 16'h0101);
    chk(SW_CLK_O, 2'b01);
    IOUT_CODE_I = 24'h123F38;
    tick(2);
    chk(IOUT_READ_O, 24'h123000);
    IOUT_CODE_I = 24'h1230A5;
    tick(200);
    chk(IOUT_READ_O, 24'h1230A5);
    chk(RAIL_STATE_O, 16'h0101);
    $display("readback and gating done");
    VIN_CODE_I = 8'h40;
    tick(1);
    RAIL_CONTROL_PIN_I = 2'h0;
    tick(3);
    chk(RAIL_STATE_O[7:0], 8'h01);
    VIN_CODE_I = 8'h50;
    wait_st(8'h02, 3);
    wait_st(8'h04, 400);
    chk(HIGH_SIDE_GATE_DRIVE_EN_O[0], 1'b0);
    OPERATION_ON_I = 2'h3;
    OC_SENSE_I = 2'h2;
    OC_LATCH_I = 2'h2;
    tick(40);
    chk(RAIL_STATE_O, 16'h8004);
    OPERATION_ON_I = 2'h1;
    tick(2);
    chk(RAIL_STATE_O[15:8], 8'h01);
    wait_st(8'h08, 62000);
    chk(w > 59000 && w < 61000, 1'b1);
    chk(LOW_SIDE_ONTIME_O[7:0], 8'h20);
    tick(3);
    chk(POWER_GOOD_OUTPUT_O, 2'b01);
    $display("startup done");
    over = 1;
    wait_st(8'h20, 4);
    tick(1);
    chk(POWER_GOOD_OUTPUT_O[0], 1'b0);
    over = 0;
    wait_st(8'h08, 5);
    $display("overvoltage done");
    RAIL_CONTROL_PIN_I = 2'h1;
    wait_st(8'h10, 3);
    chk(POWER_GOOD_OUTPUT_O[0], 1'b0);
    wait_st(8'h01, 500);
    chk(w > 250, 1'b1);
    $display("shutdown done");
    SYNC_EN_I = 1;
    repeat (2) begin
      w = SW_CLK_O[0];
      SYNC_I = 1;
      tick(2);
      chk(SW_CLK_O[0], !w);
      SYNC_I = 0;
      tick(2);
    end
    $display("sync done");
    results();
  end
endmodule : rsfs_top_tb
